// >>> hw/rcp_pkg.sv
// package: register map, field layout, mode codes and carriers for the ref clock block
package rcp_pkg;

  // ------------------------------------------------------------
  // register map (word addresses over wishbone, byte address = 4*index)
  // ------------------------------------------------------------
  localparam logic [3:0]  ADDR_REF_CTRL    = 4'h0;  // ref_clock_output_control
  localparam logic [3:0]  ADDR_PWR_CTRL    = 4'h1;  // power mode / system config
  localparam logic [3:0]  ADDR_PWR_STAT    = 4'h2;  // power mode status
  localparam int          ADDR_MSB         = 5;
  localparam int          ADDR_LSB         = 2;

  // ------------------------------------------------------------
  // ref_clock_output_control fields
  // ------------------------------------------------------------
  localparam int          REF_EN_BIT       = 15;
  localparam int          REF_SLP_BIT      = 13;
  localparam int          REF_SEL_BIT      = 12;
  localparam int          REF_DIV_MSB      = 11;
  localparam int          REF_DIV_LSB      = 8;
  localparam logic [15:0] REF_WR_MASK      = 16'hbf00;
  localparam logic [15:0] REF_RESET        = 16'h0000;

  // ------------------------------------------------------------
  // power control fields
  // ------------------------------------------------------------
  localparam int          PC_WDT_EN_BIT    = 0;
  localparam int          PC_FSM_EN_BIT    = 1;
  localparam int          PC_POSC_KEEP_BIT = 2;
  localparam int          PC_USB_EN_BIT    = 3;
  localparam int          PC_OSC_MSB       = 6;
  localparam int          PC_OSC_LSB       = 4;
  localparam logic [6:0]  PC_WR_MASK       = 7'h7f;
  localparam logic [6:0]  PC_RESET         = 7'h00;

  // divider width: 2^15 is the largest ratio, half period up to 2^14
  localparam int          DIV_W            = 15;
  localparam logic [DIV_W-1:0] DIV_ONE     = 15'h0001;
  localparam logic [DIV_W-1:0] DIV_ZERO    = 15'h0000;

  // ------------------------------------------------------------
  // oscillator modes (system clock source codes)
  // ------------------------------------------------------------
  localparam logic [2:0]  OSC_FRC          = 3'h0;
  localparam logic [2:0]  OSC_FAST_RC_PLL_MODE       = 3'h1;
  localparam logic [2:0]  OSC_PRI          = 3'h2;
  localparam logic [2:0]  OSC_PRIPLL       = 3'h3;
  localparam logic [2:0]  OSC_SOSC         = 3'h4;
  localparam logic [2:0]  OSC_LOW_POWER_RC_OSC         = 3'h5;

  // power-save instruction operand
  localparam logic        PS_SLEEP         = 1'b0;
  localparam logic        PS_IDLE          = 1'b1;

  // power mode states
  typedef enum logic [1:0] {
    RCP_RUN   = 2'b00,
    RCP_IDLE  = 2'b01,
    RCP_SLEEP = 2'b10
  } rcp_mode_t;

  // wishbone request carrier
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } rcp_wb_req_t;

  // clock enables handed to the rest of the device
  typedef struct packed {
    logic cpu_run;
    logic sys_clk_on;
    logic periph_sys_on;
    logic fsm_on;
    logic low_power_rc_osc_on;
    logic posc_on;
  } rcp_clk_en_t;

endpackage : rcp_pkg

// >>> hw/rcp_ref_div.sv
// power-of-two reference divider producing a square wave from base clock ticks
module rcp_ref_div (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             run,      // divider allowed to run
  input  wire logic             tick,     // one base clock edge pulse
  input  wire logic       [3:0] divisor,  // ratio is 2^divisor
  output logic                  ref_out
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  localparam int DIV_W = rcp_pkg::DIV_W;  // local copy for size casts
  logic [rcp_pkg::DIV_W-1:0] cnt_ff;      // base ticks counted
  logic [3:0]                div_ff;      // divisor last used
  logic                      ref_ff;      // divided level
  logic [rcp_pkg::DIV_W-1:0] half_limit;  // ticks per half period minus one
  logic                      restart;     // disable or divisor change
  logic                      wrap;        // half period done

  assign half_limit = (divisor == 4'h0) ? rcp_pkg::DIV_ZERO
                    : DIV_W'((rcp_pkg::DIV_ONE << (divisor - 4'h1)) - rcp_pkg::DIV_ONE);
  assign restart    = !run || (divisor != div_ff);
  assign wrap       = (cnt_ff == half_limit);

  // ------------------------------------------------------------
  // divider counter
  // ------------------------------------------------------------
  // restart and square wave
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= rcp_pkg::DIV_ZERO;
      div_ff <= 4'h0;
      ref_ff <= 1'b0;
    end else if (ce) begin
      div_ff <= divisor;
      if (restart) begin
        // restart low so the first half period is full length
        cnt_ff <= rcp_pkg::DIV_ZERO;
        ref_ff <= 1'b0;
      end else if (divisor == 4'h0) begin
        ref_ff <= tick;
      end else if (tick) begin
        cnt_ff <= wrap ? rcp_pkg::DIV_ZERO : DIV_W'(cnt_ff + rcp_pkg::DIV_ONE);
        if (wrap) begin
          ref_ff <= !ref_ff;
        end
      end
    end
  end

  assign ref_out = ref_ff;

endmodule : rcp_ref_div

// >>> hw/rcp_pwr_fsm.sv
// sleep / idle power mode sequencer
module rcp_pwr_fsm (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              ps_req,     // power-save instruction executed
  input  wire logic              ps_op,      // operand: sleep or idle
  input  wire logic              wake_irq,   // enabled interrupt pending
  input  wire logic              wdt_tmo,    // watchdog time-out
  output rcp_pkg::rcp_mode_t     mode,
  output logic                   wdt_clr,    // one-cycle watchdog clear
  output logic                   wake        // one-cycle wake pulse
);

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  rcp_pkg::rcp_mode_t mode_ff;
  rcp_pkg::rcp_mode_t nxt_mode;
  logic               wdt_clr_ff;
  logic               wake_ff;
  logic               wake_ev;     // any wake source
  logic               enter;       // accepted entry

  assign wake_ev = wake_irq || wdt_tmo;
  // only the instruction enters a low-power mode
  assign enter   = ps_req && (mode_ff == rcp_pkg::RCP_RUN);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      rcp_pkg::RCP_RUN: begin
        if (enter) begin
          nxt_mode = (ps_op == rcp_pkg::PS_IDLE) ? rcp_pkg::RCP_IDLE : rcp_pkg::RCP_SLEEP;
        end
      end
      rcp_pkg::RCP_IDLE,
      rcp_pkg::RCP_SLEEP: begin
        if (wake_ev) begin
          nxt_mode = rcp_pkg::RCP_RUN;
        end
      end
      default: begin
        nxt_mode = rcp_pkg::RCP_RUN;
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers; reset is itself a wake source
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ff    <= rcp_pkg::RCP_RUN;
      wdt_clr_ff <= 1'b0;
      wake_ff    <= 1'b0;
    end else if (ce) begin
      mode_ff    <= nxt_mode;
      // clear watchdog on sleep and idle entry
      wdt_clr_ff <= enter;
      wake_ff    <= (mode_ff != rcp_pkg::RCP_RUN) && (nxt_mode == rcp_pkg::RCP_RUN);
    end
  end

  assign mode    = mode_ff;
  assign wdt_clr = wdt_clr_ff;
  assign wake    = wake_ff;

endmodule : rcp_pwr_fsm

// >>> hw/rcp_top.sv
// reference clock output generator and sleep / idle power control, wishbone slave

// Functional notes
// - enable bit drives divided clock onto pin
// - divisor field divides by two to field
// - source bit picks primary osc or sysclk
// - run-in-sleep bit keeps output in sleep only from primary osc with primary kept; sysclk source gives no ticks in sleep
// - bit 14 and low byte read zero
// - output works in every oscillator mode
// - only the instruction enters sleep/idle
// - sleep stops system clock, and primary osc unless kept
// - fail-safe monitor stops in sleep
// - low-power rc runs in sleep with watchdog
// - watchdog cleared on sleep and idle entry
// - sysclk peripherals off in sleep
// - wake on interrupt, reset, watchdog time-out
// - sleep wake resumes the same clock source
// - idle stops cpu, clock keeps running
// - idle keeps rc if watchdog or monitor
// - idle wake restarts cpu at once
// - usb only with primary or primary pll
module rcp_top (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,            // freezes all state when low
  // wishbone classic slave
  input  wire rcp_pkg::rcp_wb_req_t  wb_req,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  // base clock ticks (one-cycle pulses per base clock edge)
  input  wire logic                  posc_tick,
  input  wire logic                  sys_tick,
  // cpu power-save interface
  input  wire logic                  ps_req,
  input  wire logic                  ps_op,
  input  wire logic                  wake_irq,
  input  wire logic                  wdt_tmo,
  // pins and enables
  output logic                       ref_clock_pin_o,
  output logic                       ref_clock_pin_oe,
  output rcp_pkg::rcp_clk_en_t       clk_en,
  output logic                       watchdog_clr,
  output logic                       usb_clk_ok,
  output logic [2:0]                 osc_src
);

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  localparam int AW = rcp_pkg::ADDR_MSB - rcp_pkg::ADDR_LSB + 1;

  logic [15:0]       ref_ctrl_ff;     // ref_clock_output_control
  logic [6:0]        pwr_ctrl_ff;     // watchdog/monitor/keep/usb/osc
  logic [2:0]        sleep_src_ff;    // clock source latched at sleep entry
  logic              ack_ff;
  logic [31:0]       dat_ff;
  logic [AW-1:0]     word_adr;
  logic              req;             // new access this cycle
  logic              wr_ref;
  logic              wr_pwr;
  logic              lo_lane;
  logic              hi_lane;
  logic [15:0]       lane_mask;
  logic [15:0]       ref_wdata;
  logic [6:0]        pwr_wdata;
  logic [31:0]       rd_mux;

  assign word_adr  = wb_req.adr[rcp_pkg::ADDR_MSB:rcp_pkg::ADDR_LSB];
  // ack drops for one cycle after each answer
  assign req       = wb_req.cyc && wb_req.stb && !ack_ff;
  assign lo_lane   = wb_req.sel[0];
  assign hi_lane   = wb_req.sel[1];
  assign lane_mask = {{8{hi_lane}}, {8{lo_lane}}};
  assign wr_ref    = req && wb_req.we && (word_adr == rcp_pkg::ADDR_REF_CTRL);
  assign wr_pwr    = req && wb_req.we && lo_lane && (word_adr == rcp_pkg::ADDR_PWR_CTRL);

  // reserved bits masked on write so they read zero
  assign ref_wdata = (ref_ctrl_ff & ~(lane_mask & rcp_pkg::REF_WR_MASK))
                   | (wb_req.dat[15:0] & lane_mask & rcp_pkg::REF_WR_MASK);
  assign pwr_wdata = wb_req.dat[6:0] & rcp_pkg::PC_WR_MASK;

  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  logic              ref_en;
  logic              ref_slp;
  logic              ref_sel;
  logic [3:0]        ref_div;
  logic              wdt_en;
  logic              fsm_en;
  logic              posc_keep;
  logic              usb_en;
  logic [2:0]        osc_mode;

  assign ref_en    = ref_ctrl_ff[rcp_pkg::REF_EN_BIT];
  assign ref_slp   = ref_ctrl_ff[rcp_pkg::REF_SLP_BIT];
  assign ref_sel   = ref_ctrl_ff[rcp_pkg::REF_SEL_BIT];
  assign ref_div   = ref_ctrl_ff[rcp_pkg::REF_DIV_MSB:rcp_pkg::REF_DIV_LSB];
  assign wdt_en    = pwr_ctrl_ff[rcp_pkg::PC_WDT_EN_BIT];
  assign fsm_en    = pwr_ctrl_ff[rcp_pkg::PC_FSM_EN_BIT];
  assign posc_keep = pwr_ctrl_ff[rcp_pkg::PC_POSC_KEEP_BIT];
  assign usb_en    = pwr_ctrl_ff[rcp_pkg::PC_USB_EN_BIT];
  assign osc_mode  = pwr_ctrl_ff[rcp_pkg::PC_OSC_MSB:rcp_pkg::PC_OSC_LSB];

  // ------------------------------------------------------------
  // power mode sequencer
  // ------------------------------------------------------------
  rcp_pkg::rcp_mode_t mode;
  logic               fsm_wdt_clr;
  logic               fsm_wake;
  logic               in_sleep;
  logic               in_idle;
  logic               sleep_entry;

  rcp_pwr_fsm u_pwr (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .ps_req   (ps_req),
    .ps_op    (ps_op),
    .wake_irq (wake_irq),
    .wdt_tmo  (wdt_tmo),
    .mode     (mode),
    .wdt_clr  (fsm_wdt_clr),
    .wake     (fsm_wake)
  );

  assign in_sleep    = (mode == rcp_pkg::RCP_SLEEP);
  assign in_idle     = (mode == rcp_pkg::RCP_IDLE);
  assign sleep_entry = ps_req && (ps_op == rcp_pkg::PS_SLEEP)
                    && (mode == rcp_pkg::RCP_RUN);

  // ------------------------------------------------------------
  // reference source and divider
  // ------------------------------------------------------------
  logic posc_alive;   // primary osc running
  logic base_tick;
  logic div_run;
  logic div_out;

  // primary osc survives sleep only when kept alive
  assign posc_alive = !in_sleep || posc_keep;
  // source select: primary osc or live system clock
  // either source is valid in any oscillator mode
  assign base_tick  = ref_sel ? (posc_tick && posc_alive) : (sys_tick && !in_sleep);
  // stop in sleep unless run-in-sleep set
  assign div_run    = ref_en && (!in_sleep || ref_slp);

  rcp_ref_div u_div (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .run     (div_run),
    .tick    (base_tick),
    .divisor (ref_div),
    .ref_out (div_out)
  );

  // ------------------------------------------------------------
  // clock enables for the rest of the device
  // ------------------------------------------------------------
  rcp_pkg::rcp_clk_en_t nxt_clk_en;

  always_comb begin
    // cpu clock reapplied as soon as mode returns to run
    nxt_clk_en.cpu_run       = !in_sleep && !in_idle;
    // sleep shuts the system clock; primary osc stays on only with posc_keep
    nxt_clk_en.sys_clk_on    = !in_sleep;
    // system clocked peripherals off in sleep
    nxt_clk_en.periph_sys_on = !in_sleep;
    nxt_clk_en.fsm_on        = fsm_en && !in_sleep;
    // idle keeps rc with watchdog or monitor
    nxt_clk_en.low_power_rc_osc_on       = in_sleep ? wdt_en : (wdt_en || fsm_en);
    nxt_clk_en.posc_on       = posc_alive;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0] nxt_ref_ctrl;
  logic [6:0]  nxt_pwr_ctrl;
  logic        usb_src_ok;

  assign nxt_ref_ctrl = wr_ref ? ref_wdata : ref_ctrl_ff;
  assign nxt_pwr_ctrl = wr_pwr ? pwr_wdata : pwr_ctrl_ff;
  // usb clock only from primary or primary pll
  assign usb_src_ok   = (osc_mode == rcp_pkg::OSC_PRI) || (osc_mode == rcp_pkg::OSC_PRIPLL);

  // control registers and clock source capture
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_ctrl_ff  <= rcp_pkg::REF_RESET;
      pwr_ctrl_ff  <= rcp_pkg::PC_RESET;
      sleep_src_ff <= rcp_pkg::OSC_FRC;
    end else if (ce) begin
      ref_ctrl_ff  <= nxt_ref_ctrl;
      pwr_ctrl_ff  <= nxt_pwr_ctrl;
      // remember the source active at sleep entry
      if (sleep_entry) begin
        sleep_src_ff <= osc_mode;
      end
    end
  end

  // ------------------------------------------------------------
  // read mux: status shows mode, captured source and usb source ok
  // ------------------------------------------------------------
  // bit 14 and low byte are never stored
  assign rd_mux = (word_adr == rcp_pkg::ADDR_REF_CTRL) ? {16'h0000, ref_ctrl_ff}
                : (word_adr == rcp_pkg::ADDR_PWR_CTRL) ? {25'h0000000, pwr_ctrl_ff}
                : (word_adr == rcp_pkg::ADDR_PWR_STAT) ? {26'h0000000, usb_src_ok,
                                                           sleep_src_ff, mode}
                : 32'h00000000;

  // bus answer: one wait-free ack, unmapped reads return zero
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else if (ce) begin
      ack_ff <= req;
      dat_ff <= (req && !wb_req.we) ? rd_mux : 32'h00000000;
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  logic                 pin_ff;
  logic                 pin_oe_ff;
  rcp_pkg::rcp_clk_en_t clk_en_ff;
  logic                 wdt_clr_ff;
  logic                 usb_ok_ff;
  logic [2:0]           osc_src_ff;

  // output flops; during sleep the source shown is the captured one
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_ff     <= 1'b0;
      pin_oe_ff  <= 1'b0;
      clk_en_ff  <= '0;
      wdt_clr_ff <= 1'b0;
      usb_ok_ff  <= 1'b0;
      osc_src_ff <= rcp_pkg::OSC_FRC;
    end else if (ce) begin
      pin_oe_ff  <= ref_en;
      pin_ff     <= div_out && ref_en;
      clk_en_ff  <= nxt_clk_en;
      // watchdog clear pulse when watchdog enabled
      wdt_clr_ff <= fsm_wdt_clr && wdt_en;
      usb_ok_ff  <= usb_en && usb_src_ok;
      // show the source captured at entry while in sleep, the osc field otherwise
      osc_src_ff <= in_sleep ? sleep_src_ff : osc_mode;
    end
  end

  assign wb_dat_o         = dat_ff;
  assign wb_ack_o         = ack_ff;
  assign ref_clock_pin_o  = pin_ff;
  assign ref_clock_pin_oe = pin_oe_ff;
  assign clk_en           = clk_en_ff;
  assign watchdog_clr     = wdt_clr_ff;
  assign usb_clk_ok       = usb_ok_ff;
  assign osc_src          = osc_src_ff;

endmodule : rcp_top

// >>> testbench/rcp_top_monitor.sv
// port checker for the ref clock output and power mode block
module rcp_top_monitor (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 ce,
  input wire rcp_pkg::rcp_wb_req_t wb_req,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire logic                 ps_req,
  input wire logic                 ps_op,
  input wire logic                 wake_irq,
  input wire logic                 wdt_tmo,
  input wire rcp_pkg::rcp_clk_en_t clk_en,
  input wire logic                 watchdog_clr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // bus and power mode relations
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // request taken in run with no wake pending, so entry cannot be cut short
  wire logic ps_run = ce && ps_req && clk_en.cpu_run && !wake_irq && !wdt_tmo;
  property p_ack_one;
    ce && wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("no ack after request");
  property p_ack_drop;
    ce && wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held too long");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_rsv_zero;
    wb_ack_o && !wb_req.we && wb_req.adr[5:2] == rcp_pkg::ADDR_REF_CTRL
      |-> wb_dat_o[14] == 1'b0 && wb_dat_o[7:0] == 8'h00;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("unused bits set");
  property p_wdt_clr;
    watchdog_clr |-> $past(ps_req, 2);
  endproperty
  a_wdt_clr: assert property (p_wdt_clr) else $error("stray watchdog clear");
  property p_sleep;
    ps_run && ps_op == rcp_pkg::PS_SLEEP |-> ##[1:3] !clk_en.sys_clk_on && !clk_en.cpu_run;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  property p_idle;
    ps_run && ps_op == rcp_pkg::PS_IDLE |-> ##[1:3] !clk_en.cpu_run && clk_en.sys_clk_on;
  endproperty
  a_idle: assert property (p_idle) else $error("idle not entered");
  property p_fsm_off;
    !clk_en.sys_clk_on |-> !clk_en.fsm_on;
  endproperty
  a_fsm_off: assert property (p_fsm_off) else $error("monitor on without clock");
  property p_periph_off;
    !clk_en.sys_clk_on |-> !clk_en.periph_sys_on;
  endproperty
  a_periph_off: assert property (p_periph_off) else $error("peripherals on");
  property p_wake;
    ce && !clk_en.cpu_run && (wake_irq || wdt_tmo) |-> ##[1:3] clk_en.cpu_run;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
endmodule : rcp_top_monitor

// >>> testbench/rcp_ref_sink.sv
// far side: a device sampling the reference pin on the bench clock, measuring its period
module rcp_ref_sink (
  input  wire logic clk,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output int        period,
  output int        edges
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt;
  logic last;
  // undriven pin is pulled low, so a disabled output gives no edges
  wire logic lvl = pin_oe & pin_o;
  initial begin
    cnt = 0;
    last = 1'b0;
    period = 0;
    edges = 0;
  end
  // cycles between rising edges of the pin
  always @(posedge clk) begin
    last <= lvl;
    cnt  <= (lvl && !last) ? 1 : cnt + 1;
    if (lvl && !last) begin
      period <= cnt;
      edges  <= edges + 1;
    end
  end
endmodule : rcp_ref_sink

// >>> testbench/ref_clock_out_and_power_modes_test.sv
// self-checking bench for the ref clock output and power mode block
module ref_clock_out_and_power_modes_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  rcp_pkg::rcp_wb_req_t req = '0;
  logic                 posc_tick = 1'b0;
  logic                 sys_tick = 1'b0;
  logic                 ps_req = 1'b0;
  logic                 ps_op = 1'b0;
  logic                 wake_irq = 1'b0;
  logic                 wdt_tmo = 1'b0;
  logic                 ce = 1'b1;
  logic                 clr_seen = 1'b0;
  logic [1:0]           tcnt = 2'h0;
  logic [31:0]          rnd = 32'h8f6b88f5;
  logic [31:0]          dat_o, q;
  logic                 ack, pin_o, pin_oe, wclr, usb_ok;
  logic [2:0]           osc_src;
  rcp_pkg::rcp_clk_en_t clk_en;
  int                   mdl [8];
  int                   n_fail = 0;
  int                   check_count = 0;
  int                   period, edges, e0, k;
  always #4 clk = ~clk;
  // system tick every 2 cycles, primary tick every 4, so sources differ
  always @(posedge clk) begin
    tcnt      <= tcnt + 2'h1;
    sys_tick  <= ~tcnt[0];
    posc_tick <= (tcnt == 2'h0);
    if (wclr) clr_seen <= 1'b1;
  end
  rcp_top uut (.clk(clk), .rst(rst), .ce(ce), .wb_req(req), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .posc_tick(posc_tick), .sys_tick(sys_tick), .ps_req(ps_req),
    .ps_op(ps_op), .wake_irq(wake_irq), .wdt_tmo(wdt_tmo), .ref_clock_pin_o(pin_o),
    .ref_clock_pin_oe(pin_oe), .clk_en(clk_en), .watchdog_clr(wclr),
    .usb_clk_ok(usb_ok), .osc_src(osc_src));
  rcp_ref_sink u_sink (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .period(period),
    .edges(edges));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  // a used-up bound is a mismatch and ends the run
  task automatic tmo(input int lim);
    if (k >= lim) begin
      n_fail++;
      close_out();
    end
  endtask : tmo
  // classic cycle: request stands until ack is sampled high
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, 4'hf, {26'h0, a, 2'h0}, d};
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    q = dat_o;
    req <= '0;
    tmo(20);
  endtask : bus
  // model keeps only the implemented bits of each register
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    if (a == rcp_pkg::ADDR_REF_CTRL) mdl[a] = d & rcp_pkg::REF_WR_MASK;
    if (a == rcp_pkg::ADDR_PWR_CTRL) mdl[a] = d & rcp_pkg::PC_WR_MASK;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 32'h0);
    chk(q, mdl[a], "register readback");
  endtask : rd
  task automatic run_wait(input logic v);
    for (k = 0; k < 50 && clk_en.cpu_run !== v; k++) @(posedge clk);
    tmo(50);
  endtask : run_wait
  task automatic edge_wait(input int n);
    e0 = edges;
    for (k = 0; k < 400 && edges < e0 + n; k++) @(posedge clk);
    tmo(400);
  endtask : edge_wait
  task automatic psave(input logic op);
    @(posedge clk);
    clr_seen = 1'b0;
    ps_req <= 1'b1;
    ps_op  <= op;
    @(posedge clk);
    ps_req <= 1'b0;
    run_wait(1'b0);
    @(posedge clk); // the clear flag is set on the edge that ends the wait
  endtask : psave
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(rcp_pkg::ADDR_REF_CTRL);
    wr(4'h7, 32'hffff_ffff);
    rd(4'h7);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wr(rcp_pkg::ADDR_REF_CTRL, rnd);
      rd(rcp_pkg::ADDR_REF_CTRL);
    end
    $display("test registers done");
    for (int s = 0; s < 2; s++) begin
      for (int dv = 0; dv < 4; dv++) begin
        wr(rcp_pkg::ADDR_REF_CTRL, 32'h8000 | (s << 12) | (dv << 8));
        edge_wait(3);
        chk(pin_oe, 1, "pin not driven");
        chk(period, (s ? 4 : 2) << dv, "ref period");
      end
    end
    wr(rcp_pkg::ADDR_REF_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk(pin_oe, 0, "pin still driven");
    $display("test divider done");
    // primary mode, primary kept, watchdog on; ref from primary osc, run-in-sleep set on the second pass only
    wr(rcp_pkg::ADDR_PWR_CTRL, 32'h25);
    for (int s = 0; s < 2; s++) begin
      wr(rcp_pkg::ADDR_REF_CTRL, 32'h9100 | (s << 13));
      edge_wait(2);
      psave(rcp_pkg::PS_SLEEP);
      chk(clr_seen, 1, "no watchdog clear");
      chk(clk_en.sys_clk_on, 0, "clock in sleep");
      chk(clk_en.low_power_rc_osc_on, 1, "rc osc off");
      chk(clk_en.posc_on, 1, "primary osc off");
      repeat (4) @(posedge clk);
      e0 = edges;
      repeat (40) @(posedge clk);
      chk(edges > e0, s, "ref in sleep");
      // usb source ok, captured primary source, sleep mode
      mdl[2] = 32'h20 | (rcp_pkg::OSC_PRI << 2) | rcp_pkg::RCP_SLEEP;
      rd(rcp_pkg::ADDR_PWR_STAT);
      wake_irq <= 1'b1;
      run_wait(1'b1);
      wake_irq <= 1'b0;
      chk(osc_src, rcp_pkg::OSC_PRI, "source after wake");
    end
    $display("test sleep done");
    for (int p = 0; p < 3; p++) begin
      wr(rcp_pkg::ADDR_PWR_CTRL, p);
      psave(rcp_pkg::PS_IDLE);
      chk(clr_seen, p == 1, "idle watchdog clear");
      chk(clk_en.periph_sys_on, 1, "peripherals stopped");
      chk(clk_en.low_power_rc_osc_on, p != 0, "idle rc osc");
      wdt_tmo <= 1'b1;
      run_wait(1'b1);
      wdt_tmo <= 1'b0;
    end
    $display("test idle done");
    // all six oscillator codes swept, fast rc pll included; its postscaler sits outside this block
    wr(rcp_pkg::ADDR_REF_CTRL, 32'h8100);
    for (int m = 0; m < 6; m++) begin
      wr(rcp_pkg::ADDR_PWR_CTRL, 32'h08 | (m << 4));
      rd(rcp_pkg::ADDR_PWR_CTRL);
      chk(usb_ok, m == 2 || m == 3, "usb source");
      chk(osc_src, m, "system source");
      edge_wait(2);
      chk(period, 4, "ref in every mode");
    end
    // clock enable low must freeze the divider and the pin
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    e0 = edges;
    repeat (20) @(posedge clk);
    chk(edges, e0, "ref runs with ce low");
    ce <= 1'b1;
    $display("test modes done");
    close_out();
  end
endmodule : ref_clock_out_and_power_modes_test

bind rcp_top rcp_top_monitor u_mon (.clk(clk), .rst(rst), .ce(ce), .wb_req(wb_req),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ps_req(ps_req), .ps_op(ps_op),
  .wake_irq(wake_irq), .wdt_tmo(wdt_tmo), .clk_en(clk_en), .watchdog_clr(watchdog_clr));
